// ==== logic/dts_pkg.sv ====
package dts_pkg;
    // packet word order on the command path
    localparam int unsigned DTS_PKT_WORDS = 4;
    localparam logic [1:0] DTS_W_OP = 2'h0;
    localparam logic [1:0] DTS_W_CYL = 2'h1;
    localparam logic [1:0] DTS_W_HEAD = 2'h2;
    localparam logic [1:0] DTS_W_SECT = 2'h3;
    // command codes carried in the op word
    localparam logic [15:0] DTS_OP_READ = 16'h0001;
    localparam logic [15:0] DTS_OP_WRITE = 16'h0002;
    localparam logic [15:0] DTS_OP_RECAL = 16'h0003;
    localparam logic [15:0] DTS_OP_OFFSET = 16'h0004;
    // geometry limits
    localparam logic [15:0] DTS_MAX_CYL = 16'h0400;
    localparam logic [15:0] DTS_MAX_HEAD = 16'h0010;
    localparam logic [15:0] DTS_MAX_SECT = 16'h0020;
    // bytes per sector written
    localparam logic [9:0] DTS_SECTOR_BYTES = 10'h20B;
    // engine control words
    localparam logic [1:0] DTS_ENG_OFF = 2'h0;
    localparam logic [1:0] DTS_ENG_READ = 2'h1;
    localparam logic [1:0] DTS_ENG_WRITE = 2'h2;
    // positioner commands
    localparam logic [2:0] DTS_POS_FOLLOW = 3'h0;
    localparam logic [2:0] DTS_POS_SEEK = 3'h1;
    localparam logic [2:0] DTS_POS_INWARD = 3'h2;
    localparam logic [2:0] DTS_POS_OUT_SLOW = 3'h3;
    // status codes returned to the controller
    localparam logic [1:0] DTS_ST_OK = 2'h0;
    localparam logic [1:0] DTS_ST_RANGE = 2'h1;
    localparam logic [1:0] DTS_ST_NO_DATA = 2'h2;
    localparam logic [1:0] DTS_ST_RECAL = 2'h3;
endpackage : dts_pkg

// ==== logic/dts_bus_if.sv ====
`timescale 1ns/1ps
interface dts_bus_if;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic cmd_ready;
    logic data_mode;
    logic sector_irq;
    logic status_valid;
    logic [1:0] status_code;
    logic hdr_match;
    logic rd_valid;
    logic [7:0] rd_data;
    logic wr_valid;
    logic [7:0] wr_data;
    logic wr_req;
    modport drive (
        input cmd_valid, cmd_word, data_mode, hdr_match, wr_valid, wr_data,
        output cmd_ready, sector_irq, status_valid, status_code, rd_valid, rd_data, wr_req
    );
    modport ctrl (
        output cmd_valid, cmd_word, data_mode, hdr_match, wr_valid, wr_data,
        input cmd_ready, sector_irq, status_valid, status_code, rd_valid, rd_data, wr_req
    );
endinterface : dts_bus_if

// ==== logic/dts_drive.sv ====
`timescale 1ns/1ps
module dts_drive
    import dts_pkg::*;
#(
    parameter int unsigned DTS_IRQ_WAIT = 4096
)(
    input wire logic i_clk,
    input wire logic i_arst_n,
    dts_bus_if.drive bus,
    input wire logic [15:0] i_sector_count,
    input wire logic i_seek_done,
    input wire logic i_sector_pulse,
    input wire logic i_guard_band,
    input wire logic i_recal_code,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    input wire logic i_eng_wr_req,
    output logic [2:0] o_pos_cmd,
    output logic [15:0] o_seek_cyl,
    output logic [15:0] o_head_sel,
    output logic [1:0] o_eng_ctrl,
    output logic o_eng_wr_valid,
    output logic [7:0] o_eng_wr_data,
    output logic o_recal_done
);
    typedef enum logic [3:0] {
        DTS_IDLE, DTS_FETCH, DTS_CHECK, DTS_SEEK, DTS_WAIT_SECT, DTS_WAIT_DATA,
        DTS_XFER, DTS_ENG_STOP, DTS_RC_IN, DTS_RC_OUT
    } dts_state_e;

    dts_state_e state;
    logic [1:0] widx;
    logic [15:0] pkt [DTS_PKT_WORDS];
    logic [15:0] offset;
    logic [15:0] target;
    logic [$clog2(DTS_IRQ_WAIT+1)-1:0] wait_cnt;
    logic pkt_ok;

    assign bus.cmd_ready = (state == DTS_IDLE) || (state == DTS_FETCH);
    assign target = pkt[DTS_W_SECT] - offset;
    assign pkt_ok = (pkt[DTS_W_OP] == DTS_OP_READ || pkt[DTS_W_OP] == DTS_OP_WRITE)
        && pkt[DTS_W_CYL] < DTS_MAX_CYL && pkt[DTS_W_HEAD] < DTS_MAX_HEAD
        && pkt[DTS_W_SECT] < DTS_MAX_SECT;

    // packet capture; recal stands alone, offset is op plus one value word
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            widx <= 2'h0;
            for (int k = 0; k < DTS_PKT_WORDS; k++)
                pkt[k] <= 16'h0000;
        end
        else if (bus.cmd_valid && bus.cmd_ready)
        begin
            pkt[widx] <= bus.cmd_word;
            widx <= (state == DTS_IDLE && (widx == 2'h1 || bus.cmd_word == DTS_OP_RECAL))
                ? 2'h0 : widx + 2'h1;
        end
        else if (state == DTS_IDLE && !bus.cmd_valid)
            widx <= 2'h0;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= DTS_IDLE;
            offset <= 16'h0000;
            wait_cnt <= '0;
            bus.sector_irq <= 1'b0;
            bus.status_valid <= 1'b0;
            bus.status_code <= DTS_ST_OK;
            o_pos_cmd <= DTS_POS_FOLLOW;
            o_seek_cyl <= 16'h0000;
            o_head_sel <= 16'h0000;
            o_eng_ctrl <= DTS_ENG_OFF;
            o_recal_done <= 1'b0;
        end
        else
        begin
            bus.status_valid <= 1'b0;
            bus.sector_irq <= 1'b0;
            o_recal_done <= 1'b0;
            case (state)
                DTS_IDLE:
                    if (bus.cmd_valid && widx == 2'h0)
                    begin
                        if (bus.cmd_word == DTS_OP_RECAL)
                        begin
                            o_pos_cmd <= DTS_POS_INWARD;
                            state <= DTS_RC_IN;
                        end
                        else if (bus.cmd_word != DTS_OP_OFFSET)
                            state <= DTS_FETCH;
                    end
                    else if (bus.cmd_valid && widx == 2'h1 && pkt[DTS_W_OP] == DTS_OP_OFFSET)
                        offset <= bus.cmd_word;
                DTS_FETCH:
                    if (bus.cmd_valid && widx == DTS_W_SECT)
                        state <= DTS_CHECK;
                DTS_CHECK:
                    if (pkt_ok)
                    begin
                        o_seek_cyl <= pkt[DTS_W_CYL];
                        o_pos_cmd <= DTS_POS_SEEK;
                        state <= DTS_SEEK;
                    end
                    else
                    begin
                        bus.status_valid <= 1'b1;
                        bus.status_code <= DTS_ST_RANGE;
                        state <= DTS_IDLE;
                    end
                DTS_SEEK:
                    if (i_seek_done)
                    begin
                        o_pos_cmd <= DTS_POS_FOLLOW;
                        o_head_sel <= pkt[DTS_W_HEAD];
                        state <= DTS_WAIT_SECT;
                    end
                DTS_WAIT_SECT:
                    if (i_sector_count == target)
                    begin
                        bus.sector_irq <= 1'b1;
                        wait_cnt <= '0;
                        state <= DTS_WAIT_DATA;
                    end
                DTS_WAIT_DATA:
                    if (bus.data_mode)
                    begin
                        o_eng_ctrl <= (pkt[DTS_W_OP] == DTS_OP_WRITE) ? DTS_ENG_WRITE
                            : DTS_ENG_READ;
                        state <= DTS_XFER;
                    end
                    else if (wait_cnt == DTS_IRQ_WAIT[$bits(wait_cnt)-1:0])
                    begin
                        bus.status_valid <= 1'b1;
                        bus.status_code <= DTS_ST_NO_DATA;
                        state <= DTS_IDLE;
                    end
                    else
                        wait_cnt <= wait_cnt + 1'b1;
                DTS_XFER:
                    if (!bus.data_mode)
                    begin
                        o_eng_ctrl <= DTS_ENG_OFF;
                        state <= DTS_ENG_STOP;
                    end
                DTS_ENG_STOP:
                begin
                    bus.status_valid <= 1'b1;
                    bus.status_code <= DTS_ST_OK;
                    state <= DTS_IDLE;
                end
                DTS_RC_IN:
                    if (i_guard_band)
                    begin
                        o_pos_cmd <= DTS_POS_OUT_SLOW;
                        state <= DTS_RC_OUT;
                    end
                DTS_RC_OUT:
                    if (i_recal_code)
                    begin
                        o_pos_cmd <= DTS_POS_FOLLOW;
                        o_recal_done <= 1'b1;
                        bus.status_valid <= 1'b1;
                        bus.status_code <= DTS_ST_RECAL;
                        state <= DTS_IDLE;
                    end
                default:
                    state <= DTS_IDLE;
            endcase
        end
    end

    // data path between bus and engine, live only while the engine runs
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            bus.rd_valid <= 1'b0;
            bus.rd_data <= 8'h00;
            o_eng_wr_valid <= 1'b0;
            o_eng_wr_data <= 8'h00;
        end
        else
        begin
            bus.rd_valid <= (o_eng_ctrl == DTS_ENG_READ) && i_rd_valid;
            bus.rd_data <= i_rd_data;
            o_eng_wr_valid <= (o_eng_ctrl == DTS_ENG_WRITE) && bus.wr_valid;
            o_eng_wr_data <= bus.wr_data;
        end
    end

    assign bus.wr_req = (o_eng_ctrl == DTS_ENG_WRITE) && i_eng_wr_req;
endmodule : dts_drive

// ==== logic/dts_ctrl.sv ====
`timescale 1ns/1ps
module dts_ctrl
    import dts_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    dts_bus_if.ctrl bus,
    input wire logic i_start,
    input wire logic [15:0] i_op,
    input wire logic [15:0] i_cyl,
    input wire logic [15:0] i_head,
    input wire logic [15:0] i_sect,
    input wire logic [15:0] i_count,
    input wire logic i_hdr_ok,
    input wire logic i_sector_start,
    input wire logic [7:0] i_wr_byte,
    output logic o_busy,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_done,
    output logic [1:0] o_status,
    output logic o_pos_known
);
    typedef enum logic [2:0] {
        DTS_C_IDLE, DTS_C_SEND, DTS_C_IRQ, DTS_C_DATA, DTS_C_END
    } dts_cstate_e;

    dts_cstate_e state;
    logic [1:0] widx;
    logic [15:0] op;
    logic [15:0] words [DTS_PKT_WORDS];
    logic [15:0] left;
    logic [9:0] bytes;
    logic in_sector;

    assign o_busy = (state != DTS_C_IDLE);
    assign bus.cmd_valid = (state == DTS_C_SEND);
    assign bus.cmd_word = words[widx];
    assign bus.hdr_match = in_sector;
    assign bus.wr_data = i_wr_byte;
    assign bus.wr_valid = in_sector && bus.wr_req && (bytes != DTS_SECTOR_BYTES)
        && (op == DTS_OP_WRITE);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= DTS_C_IDLE;
            widx <= 2'h0;
            op <= 16'h0000;
            left <= 16'h0000;
            bytes <= 10'h000;
            in_sector <= 1'b0;
            bus.data_mode <= 1'b0;
            o_done <= 1'b0;
            o_status <= DTS_ST_OK;
            o_pos_known <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            for (int k = 0; k < DTS_PKT_WORDS; k++)
                words[k] <= 16'h0000;
        end
        else
        begin
            o_done <= 1'b0;
            o_rd_valid <= bus.rd_valid && in_sector;
            o_rd_data <= bus.rd_data;
            if (bus.status_valid)
            begin
                o_status <= bus.status_code;
                if (bus.status_code == DTS_ST_RECAL)
                    o_pos_known <= 1'b1;
            end
            case (state)
                DTS_C_IDLE:
                    if (i_start)
                    begin
                        words[DTS_W_OP] <= i_op;
                        words[DTS_W_CYL] <= i_cyl;
                        words[DTS_W_HEAD] <= i_head;
                        words[DTS_W_SECT] <= i_sect;
                        op <= i_op;
                        left <= i_count;
                        widx <= 2'h0;
                        if (i_op == DTS_OP_RECAL)
                            o_pos_known <= 1'b0;
                        state <= DTS_C_SEND;
                    end
                DTS_C_SEND:
                    if (bus.cmd_ready)
                    begin
                        if (op == DTS_OP_RECAL || (op == DTS_OP_OFFSET && widx == 2'h1)
                            || widx == DTS_W_SECT)
                            state <= DTS_C_IRQ;
                        else
                            widx <= widx + 2'h1;
                    end
                DTS_C_IRQ:
                    if (bus.sector_irq)
                    begin
                        bus.data_mode <= 1'b1;
                        state <= DTS_C_DATA;
                    end
                    else if (bus.status_valid || op == DTS_OP_OFFSET)
                    begin
                        o_done <= 1'b1;
                        state <= DTS_C_IDLE;
                    end
                DTS_C_DATA:
                begin
                    if (i_sector_start)
                    begin
                        in_sector <= i_hdr_ok;
                        bytes <= 10'h000;
                        if (in_sector)
                            left <= left - 16'h0001;
                    end
                    else if (bus.wr_valid)
                        bytes <= bytes + 10'h001;
                    if (left == 16'h0000)
                    begin
                        bus.data_mode <= 1'b0;
                        in_sector <= 1'b0;
                        state <= DTS_C_END;
                    end
                end
                DTS_C_END:
                    if (bus.status_valid)
                    begin
                        o_done <= 1'b1;
                        state <= DTS_C_IDLE;
                    end
                default:
                    state <= DTS_C_IDLE;
            endcase
        end
    end
endmodule : dts_ctrl

// ==== verification/dts_bus_asserts.sv ====
`timescale 1ns/1ps
module dts_bus_asserts
    import dts_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic cmd_ready,
    input wire logic data_mode,
    input wire logic sector_irq,
    input wire logic status_valid,
    input wire logic [1:0] status_code,
    input wire logic hdr_match,
    input wire logic rd_valid,
    input wire logic wr_valid,
    input wire logic wr_req
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // interrupt issued since the last status report
    logic irq_seen;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_seen <= 1'b0;
        else if (sector_irq)
            irq_seen <= 1'b1;
        else if (status_valid)
            irq_seen <= 1'b0;
    end
    property p_cmd_hold;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command word not held");
    property p_irq_pulse;
        sector_irq |=> !sector_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
    property p_irq_cmd;
        sector_irq |-> !data_mode;
    endproperty
    a_irq_cmd: assert property (p_irq_cmd) else $error("interrupt in data mode");
    property p_mode_cause;
        $rose(data_mode) |-> irq_seen;
    endproperty
    a_mode_cause: assert property (p_mode_cause) else $error("data mode uncalled");
    property p_fifo_closed;
        data_mode |-> !cmd_ready;
    endproperty
    a_fifo_closed: assert property (p_fifo_closed) else $error("packet path open");
    property p_end_seq;
        $fell(data_mode) |-> ##[1:3] (status_valid && status_code == DTS_ST_OK);
    endproperty
    a_end_seq: assert property (p_end_seq) else $error("no shutdown status");
    property p_idle_open;
        status_valid && status_code == DTS_ST_OK |-> ##[0:1] cmd_ready;
    endproperty
    a_idle_open: assert property (p_idle_open) else $error("idle without path");
    property p_range_quiet;
        status_valid && status_code == DTS_ST_RANGE |=> !sector_irq [*8];
    endproperty
    a_range_quiet: assert property (p_range_quiet) else $error("transfer after bad packet");
    property p_wr_gate;
        wr_valid |-> wr_req && hdr_match && data_mode;
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write byte ungated");
    property p_rd_mode;
        rd_valid |-> data_mode;
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("read byte outside data mode");
endmodule : dts_bus_asserts

// ==== verification/dts_tb.sv ====
`timescale 1ns/1ps
module dts_tb
    import dts_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [15:0] sc_cnt = '0, op = '0, cyl = '0, head = '0, sect = '0, cnt = '0, ofs = '0;
    logic seek_done = 0, sec_pulse = 0, guard = 0, rcode = 0, rd_v = 0, wr_rq = 0;
    logic start = 0, hdr_ok = 0, sec_st = 0;
    logic [7:0] rd_d = '0, wbyte = '0, ew_d, c_rd_d;
    logic [2:0] pos_cmd;
    logic [15:0] seek_cyl, head_sel;
    logic [1:0] eng_ctrl, status;
    logic ew_v, recal_done, busy, c_rd_v, done, pos_known;
    int failures = 0, n_tests = 0, cyc = 0, k, wcnt;
    logic [7:0] rq[$], wq[$];
    logic [15:0] bo[4] = '{16'h0005, DTS_OP_READ, DTS_OP_READ, DTS_OP_WRITE};
    logic [15:0] bc[4] = '{16'h0000, DTS_MAX_CYL, 16'h0000, 16'h0000};
    logic [15:0] bh[4] = '{16'h0000, 16'h0000, DTS_MAX_HEAD, 16'h0000};
    logic [15:0] bs[4] = '{16'h0000, 16'h0000, 16'h0000, DTS_MAX_SECT};
    dts_bus_if bus();
    dts_drive #(.DTS_IRQ_WAIT(16)) dts_drive_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .bus(bus), .i_sector_count(sc_cnt), .i_seek_done(seek_done),
        .i_sector_pulse(sec_pulse), .i_guard_band(guard), .i_recal_code(rcode),
        .i_rd_valid(rd_v), .i_rd_data(rd_d), .i_eng_wr_req(wr_rq), .o_pos_cmd(pos_cmd),
        .o_seek_cyl(seek_cyl), .o_head_sel(head_sel), .o_eng_ctrl(eng_ctrl),
        .o_eng_wr_valid(ew_v), .o_eng_wr_data(ew_d), .o_recal_done(recal_done));
    dts_ctrl dts_ctrl_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus), .i_start(start),
        .i_op(op), .i_cyl(cyl), .i_head(head), .i_sect(sect), .i_count(cnt),
        .i_hdr_ok(hdr_ok), .i_sector_start(sec_st), .i_wr_byte(wbyte), .o_busy(busy),
        .o_rd_valid(c_rd_v), .o_rd_data(c_rd_d), .o_done(done), .o_status(status),
        .o_pos_known(pos_known));
    dts_bus_asserts dts_bus_asserts_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .cmd_valid(bus.cmd_valid), .cmd_word(bus.cmd_word), .cmd_ready(bus.cmd_ready),
        .data_mode(bus.data_mode), .sector_irq(bus.sector_irq),
        .status_valid(bus.status_valid), .status_code(bus.status_code),
        .hdr_match(bus.hdr_match), .rd_valid(bus.rd_valid), .wr_valid(bus.wr_valid),
        .wr_req(bus.wr_req));
    always #5 i_clk = ~i_clk;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task send(input logic [15:0] o, input logic [15:0] c, input logic [15:0] h,
        input logic [15:0] s);
        @(posedge i_clk);
        start <= 1'b1;
        op <= o;
        cyl <= c;
        head <= h;
        sect <= s;
        cnt <= 16'h0001;
        @(posedge i_clk);
        start <= 1'b0;
    endtask : send
    // one sector: header verdict, then read bytes from the engine
    task sector(input logic ok, input int nb);
        logic [7:0] v;
        @(posedge i_clk);
        hdr_ok <= ok;
        sec_st <= 1'b1;
        @(posedge i_clk);
        sec_st <= 1'b0;
        repeat (2) @(posedge i_clk);
        for (int i = 0; i < nb; i++)
        begin
            v = 8'($urandom);
            @(posedge i_clk);
            rd_v <= 1'b1;
            rd_d <= v;
            if (ok)
                rq.push_back(v);
        end
        @(posedge i_clk);
        rd_v <= 1'b0;
    endtask : sector
    task xfer(input logic [15:0] o, input logic [15:0] c, input logic [15:0] h,
        input logic [15:0] s, input logic [1:0] eng);
        send(o, c, h, s);
        k = 0;
        while (pos_cmd !== DTS_POS_SEEK && k < 99) begin @(negedge i_clk); k++; end
        chk(seek_cyl, c);
        @(posedge i_clk);
        seek_done <= 1'b1;
        sc_cnt <= s - ofs;
        k = 0;
        while (bus.sector_irq !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
        chk(head_sel, h);
        chk(16'(bus.sector_irq), 16'h0001);
        k = 0;
        while (eng_ctrl === DTS_ENG_OFF && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(eng_ctrl), 16'(eng));
    endtask : xfer
    task finish_xfer;
        k = 0;
        while (bus.status_valid !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(bus.status_valid), 16'h0001);
        chk(16'(bus.status_code), 16'(DTS_ST_OK));
        chk(16'(eng_ctrl), 16'(DTS_ENG_OFF));
        @(negedge i_clk);
        chk(16'(bus.cmd_ready), 16'h0001);
        chk(16'(rq.size() + wq.size()), 16'h0000);
        seek_done <= 1'b0;
    endtask : finish_xfer
    always @(posedge i_clk)
    begin
        if (c_rd_v === 1'b1)
            chk(16'(c_rd_d), rq.size() > 0 ? 16'(rq.pop_front()) : 16'h0100);
        if (ew_v === 1'b1)
        begin
            wcnt++;
            chk(16'(ew_d), wq.size() > 0 ? 16'(wq.pop_front()) : 16'h0100);
        end
        if (bus.wr_valid === 1'b1)
            wq.push_back(wbyte);
    end
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            stop_test();
        end
    end
    initial
    begin
        void'($urandom(32'h7e58847d));
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            send(bo[i], bc[i], bh[i], bs[i]);
            k = 0;
            while (bus.status_valid !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
            chk(16'(bus.status_code), 16'(DTS_ST_RANGE));
            chk(16'(pos_cmd), 16'(DTS_POS_FOLLOW));
        end
        // read at the top of every field, first header wrong
        xfer(DTS_OP_READ, DTS_MAX_CYL - 16'h0001, DTS_MAX_HEAD - 16'h0001,
            DTS_MAX_SECT - 16'h0001, DTS_ENG_READ);
        sector(1'b0, 3);
        sector(1'b1, 6);
        sector(1'b0, 0);
        finish_xfer();
        // program an offset, then write at a random place
        ofs = 16'($urandom % DTS_MAX_SECT);
        send(DTS_OP_OFFSET, ofs, 16'h0000, 16'h0000);
        k = 0;
        while (done !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(busy), 16'h0000);
        xfer(DTS_OP_WRITE, 16'($urandom % DTS_MAX_CYL), 16'($urandom % DTS_MAX_HEAD),
            16'($urandom % DTS_MAX_SECT), DTS_ENG_WRITE);
        wcnt = 0;
        sector(1'b1, 0);
        wr_rq <= 1'b1;
        repeat (540) @(posedge i_clk) wbyte <= 8'($urandom);
        wr_rq <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(16'(wcnt), 16'(DTS_SECTOR_BYTES));
        sector(1'b0, 0);
        finish_xfer();
        send(DTS_OP_RECAL, 16'h0000, 16'h0000, 16'h0000);
        k = 0;
        while (pos_cmd !== DTS_POS_INWARD && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(pos_cmd), 16'(DTS_POS_INWARD));
        @(posedge i_clk) guard <= 1'b1;
        k = 0;
        while (pos_cmd !== DTS_POS_OUT_SLOW && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(pos_cmd), 16'(DTS_POS_OUT_SLOW));
        @(posedge i_clk) guard <= 1'b0;
        rcode <= 1'b1;
        k = 0;
        while (recal_done !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(pos_cmd), 16'(DTS_POS_FOLLOW));
        @(posedge i_clk) rcode <= 1'b0;
        k = 0;
        while (pos_known !== 1'b1 && k < 99) begin @(negedge i_clk); k++; end
        chk(16'(pos_known), 16'h0001);
        chk(16'(status), 16'(DTS_ST_RECAL));
        stop_test();
    end
endmodule : dts_tb
